// [adc_pkg.sv]
// Shared constants for the converter output and power-down control block
package adc_pkg;
  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int DATA_W = 12;   // Output code width
  localparam int IN_W = 14;     // Signed sample width, wider than code to show over-range
  localparam int LATENCY = 5;   // Clocks from sampling edge to output edge
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int FULL_RECOV_US = 800;
  localparam int CORE_RECOV_US = 2;
  localparam int FULL_RECOV_CYC = FULL_RECOV_US * CLK_MHZ;
  localparam int CORE_RECOV_CYC = CORE_RECOV_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Register map (word index; byte address is four times this)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATE = 3'h1;
  localparam logic [2:0] REG_IRQ_STAT = 3'h2;
  localparam logic [2:0] REG_IRQ_MASK = 3'h3;
  // Control fields
  localparam int CTRL_W = 2;
  localparam int CTRL_CORE_PD = 0;
  localparam int CTRL_FULL_PD = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // State fields
  localparam int ST_VALID = 0;
  localparam int ST_OVR = 1;
  localparam int ST_CORE_PD = 2;
  localparam int ST_FULL_PD = 3;
  localparam int ST_WAKING = 4;
  localparam int ST_OE_N = 5;
  localparam int ST_DATA_LSB = 16;
  // Interrupt fields
  localparam int IRQ_W = 3;
  localparam int IRQ_OVR = 0;
  localparam int IRQ_PD = 1;
  localparam int IRQ_READY = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // ----------------------------------------------------------------
  // Power mode, Gray coded along run, down, wake
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_DOWN = 2'b01,
    PM_WAKE = 2'b11
  } pmode_e;
endpackage

// [smp_if.sv]
// Sample word carrier between the converter stages
`timescale 1ns/10ps
interface smp_if #(parameter int W = adc_pkg::DATA_W);
  logic [W-1:0] code;
  logic over_range_flag;
  logic vld;
  modport src (output code, output over_range_flag, output vld);
  modport snk (input code, input over_range_flag, input vld);
endinterface

// [pipe_delay.sv]
// Clearable delay line carrying code, over-range and valid together
`timescale 1ns/10ps
module pipe_delay #(
  parameter int W = adc_pkg::DATA_W,
  parameter int DEPTH = adc_pkg::LATENCY - 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic flush_in,
  smp_if.snk din,
  smp_if.src dout
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] code;
    logic [DEPTH-1:0] over_range_flag;
    logic [DEPTH-1:0] vld;
  } dly_s;

  dly_s s_q;
  dly_s s_d;

  // Refuse a line that cannot hold a word
  if (DEPTH < 1) begin : g_chk
    $error("pipe_delay: DEPTH must be at least 1");
  end

  // ----------------------------------------------------------------
  // Shift, or clear every word in flight
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (flush_in) begin
      s_d = '0;
    end else begin
      s_d.code[0] = din.code;
      s_d.over_range_flag[0] = din.over_range_flag;
      s_d.vld[0] = din.vld;
      for (int i = 1; i < DEPTH; i++) begin
        s_d.code[i] = s_q.code[i-1];
        s_d.over_range_flag[i] = s_q.over_range_flag[i-1];
        s_d.vld[i] = s_q.vld[i-1];
      end
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // Last stage drives the output straight from its flops
  assign dout.code = s_q.code[DEPTH-1];
  assign dout.over_range_flag = s_q.over_range_flag[DEPTH-1];
  assign dout.vld = s_q.vld[DEPTH-1];
endmodule // pipe_delay

// [adc_output_and_powerdown_ctrl.sv]
// Converter output coding, pipeline, power-down control and register slave
//
// Functional notes
// - Format select high gives two's complement codes, low gives offset binary.
// - Two's complement code is offset binary with its top bit inverted.
// - In offset binary, at or above top code output all ones; at or below bottom, zeros.
// - Mid-scale gives one then eleven zeros in offset binary.
// - Output enable is registered onto a release flag; data outputs stay driven, the far side floats the bus.
// - Over-range flag low inside full scale, high above or below it.
// - Over-range flag has the same latency as its data word.
// - Over-range flag stays high while samples stay beyond full scale.
// - Sample taken each rising edge appears five rising edges later.
// - Data and over-range flag are registered, changing only on rising edges.
// - Conversion runs only while both power-down inputs are low.
// - Full power-down stops core and reference; about 800 us recovery.
// - Core power-down stops core only, keeps reference; about 2 us recovery.
// - Entering power-down discards words in flight; refill takes full latency.
`timescale 1ns/10ps
module adc_output_and_powerdown_ctrl #(
  parameter int DATA_W = adc_pkg::DATA_W,
  parameter int IN_W = adc_pkg::IN_W,
  parameter int LATENCY = adc_pkg::LATENCY,
  parameter int FULL_RECOV_CYC = adc_pkg::FULL_RECOV_CYC,
  parameter int CORE_RECOV_CYC = adc_pkg::CORE_RECOV_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic signed [IN_W-1:0] SAMPLE_IN,
  input wire logic CODE_FORMAT_SELECT_IN,
  input wire logic OUTPUT_ENABLE_N_IN,
  input wire logic FULL_POWER_DOWN_IN,
  input wire logic CORE_POWER_DOWN_IN,
  input wire logic [adc_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_N_OUT,
  output logic OVER_RANGE_FLAG_OUT,
  output logic DATA_VALID_OUT,
  output logic CORE_ENABLE_OUT,
  output logic REF_ENABLE_OUT,
  output logic IRQ_OUT
);
  localparam int CNT_W = $clog2(FULL_RECOV_CYC + 1);
  localparam int IRQ_W = adc_pkg::IRQ_W;

  // ----------------------------------------------------------------
  // Timing overview
  // ----------------------------------------------------------------
  // Edge N: capture register takes the sample and its valid mark
  // Edges N+1 to N+4: words walk through the clearable delay line
  // Edge N+5: output register applies the format and shows the word
  // The over-range bit rides beside the code in every stage, so the
  // flag can never lead or lag its word by a cycle
  // Format select is read at the output edge only; a change of format
  // therefore takes effect on the very next word shown, not five later
  // A power-down request clears every stage at once, so no stale word
  // can leak out after wake-up with a valid mark on it
  // The wake counter is loaded on the edge that sees all requests low
  // and counts down to zero before capture is marked valid again
  // A clock enable held low freezes every flop, the synchroniser too

  typedef struct packed {
    logic signed [IN_W-1:0] cap_raw;
    logic cap_vld;
    adc_pkg::pmode_e pm;
    logic long_wake;
    logic [CNT_W-1:0] wake_cnt;
    logic [DATA_W-1:0] data;
    logic over_range_flag;
    logic vld;
    logic oe_n;
    logic core_en;
    logic ref_en;
    logic [adc_pkg::CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
    logic wreq;
  } top_s;

  top_s s_q;
  top_s s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic pd_full;
  logic pd_core;
  logic pd_any;
  logic [DATA_W:0] conv;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;

  smp_if #(.W(DATA_W)) dly_in ();
  smp_if #(.W(DATA_W)) dly_out ();

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (IN_W <= DATA_W || LATENCY < 2) begin : g_chk_w
    $error("Sample must be wider than the code and latency at least 2");
  end
  if (FULL_RECOV_CYC < 1 || CORE_RECOV_CYC < 1 || CORE_RECOV_CYC > FULL_RECOV_CYC) begin : g_chk_t
    $error("Recovery counts must be at least 1 and core not above full");
  end

  // ----------------------------------------------------------------
  // Reset release through two flops
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_q <= 2'h0;
    end else if (CE_IN) begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Saturating conversion to offset binary plus over-range bit
  // ----------------------------------------------------------------
  function automatic logic [DATA_W:0] to_offset(input logic signed [IN_W-1:0] smp);
    logic [DATA_W-1:0] code;
    logic over_range_flag;
    code = {~smp[DATA_W-1], smp[DATA_W-2:0]};
    over_range_flag = 1'b0;
    if (smp > $signed(IN_W'((1 << (DATA_W - 1)) - 1))) begin
      code = '1;
      over_range_flag = 1'b1;
    end else if (smp < -$signed(IN_W'(1 << (DATA_W - 1)))) begin
      code = '0;
      over_range_flag = 1'b1;
    end
    return {over_range_flag, code};
  endfunction

  // Combined power-down requests from pins and software
  assign pd_full = FULL_POWER_DOWN_IN | s_q.ctrl[adc_pkg::CTRL_FULL_PD];
  assign pd_core = CORE_POWER_DOWN_IN | s_q.ctrl[adc_pkg::CTRL_CORE_PD];
  assign pd_any = pd_full | pd_core;

  // Feed the delay line from the capture stage
  assign conv = to_offset(s_q.cap_raw);
  assign dly_in.code = conv[DATA_W-1:0];
  assign dly_in.over_range_flag = conv[DATA_W];
  assign dly_in.vld = s_q.cap_vld;

  // Middle stages; capture plus these plus the output register make the latency
  pipe_delay #(
    .W(DATA_W),
    .DEPTH(LATENCY - 1)
  ) u_dly (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .ce_in(CE_IN),
    .flush_in(pd_any),
    .din(dly_in),
    .dout(dly_out)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev = '0;
    clr = '0;

    // Power mode sequencing and recovery count
    // Run goes to down on any request, pin or software
    // Down remembers whether the reference was ever stopped, since a
    // stopped reference needs the long settling time on the way back
    // Wake returns to down on a new request and keeps the long flag,
    // so a short core power-down cannot cut a reference recovery short
    case (s_q.pm)
      adc_pkg::PM_RUN: begin
        if (pd_any) begin
          s_d.pm = adc_pkg::PM_DOWN;
          s_d.long_wake = pd_full;
        end
      end
      adc_pkg::PM_DOWN: begin
        s_d.long_wake = s_q.long_wake | pd_full;
        if (!pd_any) begin
          s_d.pm = adc_pkg::PM_WAKE;
          if (s_d.long_wake) begin
            s_d.wake_cnt = CNT_W'(FULL_RECOV_CYC - 1);
          end else begin
            s_d.wake_cnt = CNT_W'(CORE_RECOV_CYC - 1);
          end
        end
      end
      adc_pkg::PM_WAKE: begin
        if (pd_any) begin
          s_d.pm = adc_pkg::PM_DOWN;
          s_d.long_wake = s_q.long_wake | pd_full; // Reference may still be settling
        end else if (s_q.wake_cnt == '0) begin
          s_d.pm = adc_pkg::PM_RUN;
        end else begin
          s_d.wake_cnt = s_q.wake_cnt - CNT_W'(1);
        end
      end
      default: begin
        s_d.pm = adc_pkg::PM_DOWN;
        s_d.long_wake = 1'b1;
      end
    endcase

    // Core and reference enables
    s_d.ref_en = ~pd_full;
    s_d.core_en = ~pd_any;

    // Capture stage: every rising edge, valid only in settled run mode
    s_d.cap_raw = SAMPLE_IN;
    s_d.cap_vld = (s_q.pm == adc_pkg::PM_RUN) && !pd_any;

    // Output register with format applied on the way out
    if (pd_any) begin
      s_d.data = '0;
      s_d.over_range_flag = 1'b0;
      s_d.vld = 1'b0;
    end else begin
      s_d.data = dly_out.code;
      s_d.data[DATA_W-1] = dly_out.code[DATA_W-1] ^ CODE_FORMAT_SELECT_IN;
      s_d.over_range_flag = dly_out.over_range_flag;
      s_d.vld = dly_out.vld;
    end
    s_d.oe_n = OUTPUT_ENABLE_N_IN;

    // Events
    // Over-range and ready events are rising edges of what the output register will hold,
    // so a long over-range run raises one event, not one per word
    ev[adc_pkg::IRQ_OVR] = s_d.over_range_flag & ~s_q.over_range_flag;
    ev[adc_pkg::IRQ_PD] = (s_d.pm == adc_pkg::PM_DOWN) && (s_q.pm != adc_pkg::PM_DOWN);
    ev[adc_pkg::IRQ_READY] = s_d.vld & ~s_q.vld;

    // Bus slave: one wait cycle, then completion
    // First edge of a request: read data are loaded, wait request drops
    // Second edge: the write lands, the status clear is applied and wait
    // request rises again, ready for a request on the following cycle
    // Read data stand untouched until the next request's first edge
    // Only byte lane zero carries writable register bits; other lanes are ignored
    if ((AVS_READ_IN || AVS_WRITE_IN) && s_q.wreq) begin
      s_d.wreq = 1'b0;
      s_d.rdata = '0;
      if (AVS_READ_IN) begin
        case (AVS_ADDRESS_IN)
          adc_pkg::REG_CTRL: begin
            s_d.rdata[adc_pkg::CTRL_W-1:0] = s_q.ctrl;
          end
          adc_pkg::REG_STATE: begin
            s_d.rdata[adc_pkg::ST_VALID] = s_q.vld;
            s_d.rdata[adc_pkg::ST_OVR] = s_q.over_range_flag;
            s_d.rdata[adc_pkg::ST_CORE_PD] = pd_core;
            s_d.rdata[adc_pkg::ST_FULL_PD] = pd_full;
            s_d.rdata[adc_pkg::ST_WAKING] = (s_q.pm == adc_pkg::PM_WAKE);
            s_d.rdata[adc_pkg::ST_OE_N] = s_q.oe_n;
            s_d.rdata[adc_pkg::ST_DATA_LSB +: DATA_W] = s_q.data;
          end
          adc_pkg::REG_IRQ_STAT: begin
            s_d.rdata[IRQ_W-1:0] = s_q.irq_stat;
          end
          adc_pkg::REG_IRQ_MASK: begin
            s_d.rdata[IRQ_W-1:0] = s_q.irq_mask;
          end
          default: begin
            s_d.rdata = '0;
          end
        endcase
      end
    end else if ((AVS_READ_IN || AVS_WRITE_IN) && !s_q.wreq) begin
      s_d.wreq = 1'b1;
      if (AVS_WRITE_IN && AVS_BYTEENABLE_IN[0]) begin
        if (AVS_ADDRESS_IN == adc_pkg::REG_CTRL) begin
          s_d.ctrl = AVS_WRITEDATA_IN[adc_pkg::CTRL_W-1:0];
        end else if (AVS_ADDRESS_IN == adc_pkg::REG_IRQ_MASK) begin
          s_d.irq_mask = AVS_WRITEDATA_IN[IRQ_W-1:0];
        end
      end
      // Clear only the bits that were actually returned
      if (AVS_READ_IN && AVS_ADDRESS_IN == adc_pkg::REG_IRQ_STAT) begin
        clr = s_q.rdata[IRQ_W-1:0];
      end
    end else begin
      s_d.wreq = 1'b1;
    end

    // Sticky status: a new event wins over a clear
    // The clear uses the bits returned by the read, so an event that
    // arrives between the two bus edges survives for the next read
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves the core and reference running in run mode, so the
  // first word appears one latency after reset without a recovery wait
  // The data bus starts released until the enable pin has been seen
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.pm <= adc_pkg::PM_RUN;
      s_q.oe_n <= 1'b1;
      s_q.core_en <= 1'b1;
      s_q.ref_en <= 1'b1;
      s_q.ctrl <= adc_pkg::CTRL_RST;
      s_q.irq_mask <= adc_pkg::IRQ_MASK_RST;
      s_q.wreq <= 1'b1;
    end else if (CE_IN) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  // No output passes through logic after its flop, so every pin
  // changes only on a rising edge and holds steady in between
  // The release flag is a plain output; the far side floats the bus
  assign DATA_OUT = s_q.data;
  assign DATA_OE_N_OUT = s_q.oe_n;
  assign OVER_RANGE_FLAG_OUT = s_q.over_range_flag;
  assign DATA_VALID_OUT = s_q.vld;
  assign CORE_ENABLE_OUT = s_q.core_en;
  assign REF_ENABLE_OUT = s_q.ref_en;
  assign IRQ_OUT = s_q.irq;
  assign AVS_READDATA_OUT = s_q.rdata;
  assign AVS_WAITREQUEST_OUT = s_q.wreq;
endmodule // adc_output_and_powerdown_ctrl

// [adc_code_pkg.sv]
// Reference coding of one sample for the verification side
package adc_code_pkg;
  // ----------------------------------------------------------------
  // Expected over-range flag and output code
  // ----------------------------------------------------------------
  function automatic logic [12:0] code_of(input logic signed [13:0] s, input logic f);
    logic hi;
    logic lo;
    hi = s > 14'sh07ff;
    lo = s < 14'sh3800;
    return {hi | lo, (hi ? 12'hfff : lo ? 12'h000 : {~s[11], s[10:0]}) ^ {f, 11'h000}};
  endfunction
endpackage

// [adc_capture_model.sv]
// Downstream capture logic latching parallel sample words
`timescale 1ns/10ps
module adc_capture_model (
  input wire logic clk_in,
  input wire logic [11:0] data_in,
  input wire logic oe_n_in,
  input wire logic valid_in,
  input wire logic ovr_in,
  output logic [11:0] word_out,
  output logic ovr_out,
  output logic stb_out
);
  // ----------------------------------------------------------------
  // Bus level and capture register
  // ----------------------------------------------------------------
  logic [11:0] last_q;
  logic [11:0] bus_lvl;
  // Released bus shows the inverse of what was last driven
  assign bus_lvl = oe_n_in ? ~last_q : data_in;
  // Strobe a word only while the converter drives a valid one; the bus level is latched every edge
  always_ff @(posedge clk_in) begin
    if (!oe_n_in) last_q <= data_in;
    stb_out <= valid_in && !oe_n_in;
    word_out <= bus_lvl;
    ovr_out <= ovr_in;
  end
endmodule // adc_capture_model

// [adc_ctrl_asserts.sv]
// Port checks of the converter output and power-down block
`timescale 1ns/10ps
module adc_ctrl_asserts #(
  parameter int DATA_W = 12,
  parameter int IN_W = 14
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic signed [IN_W-1:0] SAMPLE_IN,
  input wire logic CODE_FORMAT_SELECT_IN,
  input wire logic OUTPUT_ENABLE_N_IN,
  input wire logic FULL_POWER_DOWN_IN,
  input wire logic CORE_POWER_DOWN_IN,
  input wire logic [adc_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic [DATA_W-1:0] DATA_OUT,
  input wire logic DATA_OE_N_OUT,
  input wire logic OVER_RANGE_FLAG_OUT,
  input wire logic DATA_VALID_OUT,
  input wire logic CORE_ENABLE_OUT,
  input wire logic REF_ENABLE_OUT
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [3:0] up_q;
  logic live;
  logic any_pd;
  // Edges since reset release, so the synchroniser delay is skipped
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) up_q <= 4'h0;
    else if (up_q != 4'hf) up_q <= up_q + 4'h1;
  end
  assign live = up_q >= 4'h5;
  assign any_pd = FULL_POWER_DOWN_IN || CORE_POWER_DOWN_IN;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  oe_follow_a: assert property (live |-> DATA_OE_N_OUT == $past(OUTPUT_ENABLE_N_IN))
    else $error("Output enable does not follow its pin");
  pd_flush_a: assert property (any_pd |=> !DATA_VALID_OUT && !OVER_RANGE_FLAG_OUT && DATA_OUT == '0)
    else $error("Words kept during power-down");
  core_off_a: assert property (live && any_pd |=> !CORE_ENABLE_OUT)
    else $error("Core still enabled in power-down");
  ref_off_a: assert property (live && FULL_POWER_DOWN_IN |=> !REF_ENABLE_OUT)
    else $error("Reference still enabled in full power-down");
  code_pipe_a: assert property (DATA_VALID_OUT |-> {OVER_RANGE_FLAG_OUT, DATA_OUT} ==
    adc_code_pkg::code_of($past(SAMPLE_IN, 6), $past(CODE_FORMAT_SELECT_IN)))
    else $error("Output word differs from sample five edges back");
  sat_code_a: assert property (OVER_RANGE_FLAG_OUT |-> DATA_OUT inside {12'h000, 12'hfff, 12'h7ff, 12'h800})
    else $error("Over-range word not saturated");
  ovr_hold_a: assert property (DATA_VALID_OUT && $past(DATA_VALID_OUT) && $past(OVER_RANGE_FLAG_OUT) &&
    ($past(SAMPLE_IN, 6) > 14'sh07ff || $past(SAMPLE_IN, 6) < 14'sh3800) |-> $stable(OVER_RANGE_FLAG_OUT))
    else $error("Over-range flag toggled during a run");
  wake_gap_a: assert property ($fell(any_pd) |-> !DATA_VALID_OUT [*5])
    else $error("Valid word before pipeline refill");
  one_wait_a: assert property (live && (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
    else $error("Bus answer not after one wait state");
  unmap_zero_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN[2]
    |-> AVS_READDATA_OUT == 32'h0)
    else $error("Unmapped read not zero");
endmodule // adc_ctrl_asserts
bind adc_output_and_powerdown_ctrl adc_ctrl_asserts #(.DATA_W(DATA_W), .IN_W(IN_W)) chk (.*);

// [adc_output_and_powerdown_ctrl_tb.sv]
// Self-checking bench of the converter output and power-down block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h seen %h", n, e, g); end end
module adc_output_and_powerdown_ctrl_tb;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int CORE_N = 5;
  localparam int FULL_N = 40;
  logic CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic CE_IN = 1'b1;
  logic signed [13:0] SAMPLE_IN = 14'h0;
  logic CODE_FORMAT_SELECT_IN = 1'b0;
  logic OUTPUT_ENABLE_N_IN = 1'b0;
  logic FULL_POWER_DOWN_IN = 1'b0;
  logic CORE_POWER_DOWN_IN = 1'b0;
  logic [2:0] AVS_ADDRESS_IN = 3'h0;
  logic AVS_READ_IN = 1'b0;
  logic AVS_WRITE_IN = 1'b0;
  logic [31:0] AVS_WRITEDATA_IN = 32'h0;
  logic [3:0] AVS_BYTEENABLE_IN = 4'hf;
  logic [31:0] AVS_READDATA_OUT, rd;
  logic [11:0] DATA_OUT, cap_word;
  logic AVS_WAITREQUEST_OUT, DATA_OE_N_OUT, OVER_RANGE_FLAG_OUT, DATA_VALID_OUT;
  logic CORE_ENABLE_OUT, REF_ENABLE_OUT, IRQ_OUT, cap_ovr, cap_stb;
  logic use_hold = 1'b0;
  logic signed [13:0] hold_val = 14'h0;
  logic signed [13:0] vals[9] = '{14'sh07ff, 14'sh0800, 14'sh1fff, 14'sh3800, 14'sh37ff,
    14'sh2000, 14'sh0000, 14'sh0400, 14'sh3c00};
  logic [31:0] rnd = 32'hd82f840a;
  logic [12:0] expq[$];
  int fails = 0;
  int tests_run = 0;
  adc_output_and_powerdown_ctrl #(.FULL_RECOV_CYC(FULL_N), .CORE_RECOV_CYC(CORE_N)) uut (.*);
  adc_capture_model far (.clk_in(CLK_IN), .data_in(DATA_OUT), .oe_n_in(DATA_OE_N_OUT),
    .valid_in(DATA_VALID_OUT), .ovr_in(OVER_RANGE_FLAG_OUT), .word_out(cap_word),
    .ovr_out(cap_ovr), .stb_out(cap_stb));
  // Clock of 100 ns
  always #50 CLK_IN = ~CLK_IN;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Drive one sample per edge and note its expected word
  always @(posedge CLK_IN) begin : drive
    logic signed [13:0] nxt;
    rnd = lfsr(rnd);
    nxt = use_hold ? hold_val : (rnd[15] ? rnd[13:0] : {{2{rnd[11]}}, rnd[11:0]});
    SAMPLE_IN <= nxt;
    expq.push_back(adc_code_pkg::code_of(nxt, CODE_FORMAT_SELECT_IN));
  end
  // Captured word belongs to the note taken seven edges earlier
  always @(negedge CLK_IN) begin : watch
    logic [12:0] e;
    if (expq.size() >= 8) begin
      e = expq.pop_front();
      if (cap_stb === 1'b1) `CHK("word", e, {cap_ovr, cap_word})
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge CLK_IN);
    AVS_ADDRESS_IN <= a;
    AVS_READ_IN <= !w;
    AVS_WRITE_IN <= w;
    AVS_WRITEDATA_IN <= d;
    AVS_BYTEENABLE_IN <= be;
    n = 0;
    do begin
      @(posedge CLK_IN);
      n++;
    end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rd = AVS_READDATA_OUT;
    AVS_READ_IN <= 1'b0;
    AVS_WRITE_IN <= 1'b0;
  endtask
  // Power down by pin or register, release and time the recovery
  task automatic pd_case(input int k);
    int n;
    logic full;
    full = k[0];
    if (k < 2) begin
      @(posedge CLK_IN);
      FULL_POWER_DOWN_IN <= full;
      CORE_POWER_DOWN_IN <= !full;
    end else begin
      bus(1'b1, 3'h0, full ? 32'h2 : 32'h1, 4'hf);
      bus(1'b0, 3'h0, 32'h0, 4'hf);
      `CHK("ctrl_rd", full ? 2'h2 : 2'h1, rd[1:0])
    end
    repeat (10) @(posedge CLK_IN);
    `CHK("core_en", 1'b0, CORE_ENABLE_OUT)
    `CHK("ref_en", !full, REF_ENABLE_OUT)
    `CHK("valid_pd", 1'b0, DATA_VALID_OUT)
    CODE_FORMAT_SELECT_IN <= !CODE_FORMAT_SELECT_IN;
    repeat (10) @(posedge CLK_IN);
    if (k < 2) begin
      FULL_POWER_DOWN_IN <= 1'b0;
      CORE_POWER_DOWN_IN <= 1'b0;
    end else bus(1'b1, 3'h0, 32'h0, 4'hf);
    n = 0;
    while (DATA_VALID_OUT !== 1'b1 && n < 200) begin
      @(posedge CLK_IN);
      n++;
    end
    `CHK("wake_min", 1'b1, n >= (full ? FULL_N : CORE_N) + 5)
    `CHK("wake_max", 1'b1, n <= (full ? FULL_N : CORE_N) + 10)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    repeat (6) @(posedge CLK_IN);
    bus(1'b0, 3'h0, 32'h0, 4'hf);
    `CHK("ctrl_rst", 32'h0, rd)
    bus(1'b1, 3'h3, 32'h7, 4'he);
    bus(1'b0, 3'h3, 32'h0, 4'hf);
    `CHK("mask_rst", 32'h0, rd)
    bus(1'b1, 3'h5, 32'hffffffff, 4'hf);
    bus(1'b0, 3'h5, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, rd)
    repeat (200) @(posedge CLK_IN);
    foreach (vals[i]) begin
      hold_val <= vals[i];
      use_hold <= 1'b1;
      repeat (3) @(posedge CLK_IN);
    end
    hold_val <= 14'h0;
    bus(1'b1, 3'h3, 32'h1, 4'hf);
    bus(1'b0, 3'h2, 32'h0, 4'hf);
    repeat (12) @(posedge CLK_IN);
    `CHK("irq_idle", 1'b0, IRQ_OUT)
    hold_val <= 14'sh0fa0;
    repeat (12) @(posedge CLK_IN);
    `CHK("irq_set", 1'b1, IRQ_OUT)
    bus(1'b0, 3'h2, 32'h0, 4'hf);
    `CHK("stat_ovr", 1'b1, rd[0])
    hold_val <= 14'h0;
    repeat (12) @(posedge CLK_IN);
    `CHK("irq_clr", 1'b0, IRQ_OUT)
    bus(1'b1, 3'h3, 32'h0, 4'hf);
    hold_val <= 14'sh3000;
    repeat (12) @(posedge CLK_IN);
    `CHK("irq_mask", 1'b0, IRQ_OUT)
    use_hold <= 1'b0;
    OUTPUT_ENABLE_N_IN <= 1'b1;
    repeat (20) @(posedge CLK_IN);
    `CHK("oe_n", 1'b1, DATA_OE_N_OUT)
    OUTPUT_ENABLE_N_IN <= 1'b0;
    for (int k = 0; k < 4; k++) pd_case(k);
    repeat (100) @(posedge CLK_IN);
    bus(1'b0, 3'h1, 32'h0, 4'hf);
    `CHK("st_valid", 1'b1, rd[0])
    `CHK("st_pd", 4'h0, rd[5:2])
    bus(1'b0, 3'h2, 32'h0, 4'hf);
    `CHK("stat_all", 3'h7, rd[2:0])
    print_verdict();
  end
  initial begin
    #(100 * 20000);
    fails++;
    print_verdict();
  end
endmodule // adc_output_and_powerdown_ctrl_tb
